// ==== hdl/p4io_pkg.sv ====
// p4io_pkg: register map, field positions, reset values and modes of the port four block
// assumes: 32-bit apb, each register on one aligned word at four times its index
package p4io_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] P4IO_DATA_IDX = 16'hffd7;
  localparam logic [15:0] P4IO_DIR_IDX  = 16'hffe7;
  localparam logic [15:0] P4IO_ALT_IDX  = 16'hfff0;
  localparam logic [31:0] P4IO_DATA_ADDR = {14'h0000, P4IO_DATA_IDX, 2'b00};
  localparam logic [31:0] P4IO_DIR_ADDR  = {14'h0000, P4IO_DIR_IDX, 2'b00};
  localparam logic [31:0] P4IO_ALT_ADDR  = {14'h0000, P4IO_ALT_IDX, 2'b00};

  // ==========================================================
  // reset and read values
  localparam logic [7:0] P4IO_DATA_RESET = 8'hf8;
  localparam logic [7:0] P4IO_DIR_RESET  = 8'hf8;
  localparam logic [7:0] P4IO_DIR_READ   = 8'hff;
  localparam logic [3:0] P4IO_UNUSED_RD  = 4'hf;
  localparam logic [6:0] P4IO_ALT_RESET  = 7'h00;

  // ==========================================================
  // pin positions
  localparam int P4IO_PIN_CLK = 0;
  localparam int P4IO_PIN_RX  = 1;
  localparam int P4IO_PIN_TX  = 2;
  localparam int P4IO_PIN_IRQ = 3;
  localparam int P4IO_NUM_IO  = 3;
  localparam int P4IO_NUM_PIN = 4;

  // ==========================================================
  // alternate function register fields
  localparam int P4IO_ALT_ISEL = 0;
  localparam int P4IO_ALT_SPC  = 1;
  localparam int P4IO_ALT_TE   = 2;
  localparam int P4IO_ALT_RE   = 3;
  localparam int P4IO_ALT_CLOCK_ENABLE_BIT0 = 4;
  localparam int P4IO_ALT_CLOCK_ENABLE_BIT1 = 5;
  localparam int P4IO_ALT_COM  = 6;
  localparam int P4IO_ALT_W    = 7;

  // ==========================================================
  // register select and operating modes
  typedef enum logic [1:0] {P4IO_SEL_NONE, P4IO_SEL_DATA, P4IO_SEL_DIR, P4IO_SEL_ALT} p4io_sel_t;
  typedef enum logic [2:0] {P4IO_ACTIVE, P4IO_SUBACTIVE, P4IO_SLEEP, P4IO_SUBSLEEP, P4IO_WATCH,
                            P4IO_STANDBY} p4io_mode_t;

endpackage : p4io_pkg

// ==== hdl/p4io_sync.sv ====
// p4io_sync: two-flop synchroniser bank for the pin levels
// assumes: inputs are asynchronous to pclk; pins idle high
module p4io_sync #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ==========================================================
  // elaboration check
  if (W < 1) begin : g_bad_width
    $error("p4io_sync: width must be at least one");
  end

  // ==========================================================
  // two stages; the first is read by the second alone
  logic [W-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '1;
      sync_out <= '1;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // p4io_sync

// ==== hdl/p4io_port.sv ====
// p4io_port: port four, three two-way pins and one input pin, with serial and interrupt pin mux
// assumes: apb master on pclk; serial unit and power control on pclk; pins asynchronous
//
// How it works
// - a data read gives the latch for pins set as outputs and the pin level for pins set as inputs.
// - only data bits 2 to 0 are latches, bit 3 shows the input pin, bits 7 to 4 read as one.
// - reset loads the data register with f8, so the three latches start at zero.
// - a direction bit of one makes its pin an output, zero makes it an input.
// - the direction register is write only, reads all ones, and resets to f8 so pins are inputs.
// - direction and data settings act on a pin only while the serial unit leaves it to the port.
// - pin 2 carries serial transmit when pin control and transmit enable are both set.
// - pin 1 is the serial receive input whenever receive enable is set.
// - pin 0 is clock input on clock enable 1, clock output on clock enable 0 or sync mode, else port.
// - pins float in reset and standby, hold in sleep, subsleep and watch, and work in active and subactive.
//
// Register access over APB was chosen for this implementation.
module p4io_port
  import p4io_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire p4io_mode_t  power_mode,
  input  wire logic        serial_transmit_out,
  input  wire logic        serial_clock_out,
  output logic             serial_receive_in,
  output logic             serial_clock_in,
  output logic             irq_request_n,
  input  wire logic [2:0]  pin_in,
  input  wire logic        pin_irq_in,
  output logic      [2:0]  pin_out,
  output logic      [2:0]  pin_oe_n
);

  // ==========================================================
  // address decode, shared by the read, write and error paths
  function automatic p4io_sel_t reg_sel(input logic [31:0] addr);
    case (addr)
      P4IO_DATA_ADDR: reg_sel = P4IO_SEL_DATA;
      P4IO_DIR_ADDR:  reg_sel = P4IO_SEL_DIR;
      P4IO_ALT_ADDR:  reg_sel = P4IO_SEL_ALT;
      default:        reg_sel = P4IO_SEL_NONE;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [3:0] pin_sync;

  p4io_sync #(
    .W        (P4IO_NUM_PIN)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pin_irq_in, pin_in}),
    .sync_out (pin_sync)
  );

  // ==========================================================
  // registers
  logic [2:0]           port_four_data;
  logic [2:0]           port_four_direction;
  logic [P4IO_ALT_W-1:0] port_four_altfunc;
  p4io_sel_t            sel;
  logic                 wr_go;

  assign sel   = reg_sel(paddr);
  assign wr_go = psel && penable && pready && pwrite && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_four_data <= P4IO_DATA_RESET[2:0];
    end else if (wr_go && sel == P4IO_SEL_DATA) begin
      port_four_data <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_four_direction <= P4IO_DIR_RESET[2:0];
    end else if (wr_go && sel == P4IO_SEL_DIR) begin
      port_four_direction <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_four_altfunc <= P4IO_ALT_RESET;
    end else if (wr_go && sel == P4IO_SEL_ALT) begin
      port_four_altfunc <= pwdata[P4IO_ALT_W-1:0];
    end
  end

  // ==========================================================
  // alternate function selects
  logic isel;
  logic tx_sel;
  logic rx_sel;
  logic ck_in_sel;
  logic ck_out_sel;

  assign isel       = port_four_altfunc[P4IO_ALT_ISEL];
  assign tx_sel     = port_four_altfunc[P4IO_ALT_SPC] && port_four_altfunc[P4IO_ALT_TE];
  assign rx_sel     = port_four_altfunc[P4IO_ALT_RE];
  assign ck_in_sel  = port_four_altfunc[P4IO_ALT_CLOCK_ENABLE_BIT1];
  assign ck_out_sel = !ck_in_sel &&
                      (port_four_altfunc[P4IO_ALT_CLOCK_ENABLE_BIT0] || port_four_altfunc[P4IO_ALT_COM]);

  // ==========================================================
  // read view of the data register
  logic [7:0] data_view;

  assign data_view = {P4IO_UNUSED_RD, pin_sync[P4IO_PIN_IRQ],
                      (port_four_direction & port_four_data) |
                      (~port_four_direction & pin_sync[2:0])};

  // ==========================================================
  // apb slave: one wait state, so read data come from a flop
  p4io_sel_t rd_sel;
  logic [7:0] next_rdata;

  assign rd_sel = reg_sel(paddr);

  always_comb begin
    next_rdata = 8'h00;
    case (rd_sel)
      P4IO_SEL_DATA: next_rdata = data_view;
      P4IO_SEL_DIR:  next_rdata = P4IO_DIR_READ;
      P4IO_SEL_ALT:  next_rdata = {1'b0, port_four_altfunc};
      default:       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
      pslverr <= (rd_sel == P4IO_SEL_NONE);
    end else begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // pin drive; port settings matter only where the serial unit leaves the pin
  logic       run_mode;
  logic       hold_mode;
  logic [2:0] next_out;
  logic [2:0] next_oe_n;

  assign run_mode  = (power_mode == P4IO_ACTIVE) || (power_mode == P4IO_SUBACTIVE);
  assign hold_mode = (power_mode == P4IO_SLEEP) || (power_mode == P4IO_SUBSLEEP) ||
                     (power_mode == P4IO_WATCH);

  always_comb begin
    next_out  = port_four_data;
    next_oe_n = ~port_four_direction;
    if (tx_sel) begin
      next_out[P4IO_PIN_TX]  = serial_transmit_out;
      next_oe_n[P4IO_PIN_TX] = 1'b0;
    end
    if (rx_sel) begin
      next_out[P4IO_PIN_RX]  = 1'b0;
      next_oe_n[P4IO_PIN_RX] = 1'b1;
    end
    if (ck_in_sel) begin
      next_out[P4IO_PIN_CLK]  = 1'b0;
      next_oe_n[P4IO_PIN_CLK] = 1'b1;
    end else if (ck_out_sel) begin
      next_out[P4IO_PIN_CLK]  = serial_clock_out;
      next_oe_n[P4IO_PIN_CLK] = 1'b0;
    end
    if (hold_mode) begin
      next_out  = pin_out;
      next_oe_n = pin_oe_n;
    end else if (!run_mode) begin
      next_out  = 3'h0;
      next_oe_n = 3'h7;
    end
  end

  // pins float while reset is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out  <= 3'h0;
      pin_oe_n <= 3'h7;
    end else begin
      pin_out  <= next_out;
      pin_oe_n <= next_oe_n;
    end
  end

  // ==========================================================
  // levels handed to the serial and interrupt units; idle levels when not selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_receive_in <= 1'b1;
      serial_clock_in   <= 1'b1;
      irq_request_n     <= 1'b1;
    end else begin
      serial_receive_in <= rx_sel ? pin_sync[P4IO_PIN_RX] : 1'b1;
      serial_clock_in   <= ck_in_sel ? pin_sync[P4IO_PIN_CLK] : 1'b1;
      irq_request_n     <= isel ? pin_sync[P4IO_PIN_IRQ] : 1'b1;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_done;
  assign rd_done = psel && penable && pready && !pwrite;

  a_data_read_mux: assert property (rd_done && sel == P4IO_SEL_DATA |->
    prdata[2:0] == $past(data_view[2:0]))
    else $error("data read does not mix latch and pin by direction");

  a_data_upper_bits: assert property (rd_done && sel == P4IO_SEL_DATA |->
    prdata[7:4] == P4IO_UNUSED_RD && prdata[3] == $past(pin_sync[P4IO_PIN_IRQ]))
    else $error("data read upper bits wrong");

  a_reset_latches: assert property (!$past(presetn) |->
    port_four_data == 3'h0 && port_four_direction == 3'h0 && pin_oe_n == 3'h7)
    else $error("latches or direction not cleared by reset");

  a_dir_reads_ones: assert property (rd_done && sel == P4IO_SEL_DIR |->
    prdata[7:0] == P4IO_DIR_READ)
    else $error("direction register does not read all ones");

  a_gpio_output: assert property (run_mode && !tx_sel && port_four_direction[P4IO_PIN_TX] |=>
    !pin_oe_n[P4IO_PIN_TX] && pin_out[P4IO_PIN_TX] == $past(port_four_data[P4IO_PIN_TX]))
    else $error("general output pin not driven from its latch");

  a_gpio_input: assert property (run_mode && !rx_sel && !port_four_direction[P4IO_PIN_RX] |=>
    pin_oe_n[P4IO_PIN_RX])
    else $error("general input pin driven");

  a_tx_override: assert property (run_mode && tx_sel |=>
    !pin_oe_n[P4IO_PIN_TX] && pin_out[P4IO_PIN_TX] == $past(serial_transmit_out))
    else $error("transmit pin not carrying serial data");

  a_rx_override: assert property (run_mode && rx_sel |=> pin_oe_n[P4IO_PIN_RX] &&
    serial_receive_in == $past(pin_sync[P4IO_PIN_RX]))
    else $error("receive pin not an input");

  a_clk_pin_mux: assert property (run_mode && ck_out_sel |=>
    !pin_oe_n[P4IO_PIN_CLK] && pin_out[P4IO_PIN_CLK] == $past(serial_clock_out))
    else $error("clock pin not driving serial clock");

  a_irq_select: assert property (!isel |=> irq_request_n)
    else $error("interrupt request active while not selected");

  a_standby_float: assert property (power_mode == P4IO_STANDBY |=> pin_oe_n == 3'h7)
    else $error("pins driven in standby");

  a_hold_state: assert property (hold_mode |=> $stable(pin_oe_n) && $stable(pin_out))
    else $error("pins changed in a holding mode");

  a_data_write: assert property (wr_go && sel == P4IO_SEL_DATA |=>
    port_four_data == $past(pwdata[2:0]))
    else $error("data latches did not take the written value");

  a_dir_write: assert property (wr_go && sel == P4IO_SEL_DIR |=>
    port_four_direction == $past(pwdata[2:0]))
    else $error("direction bits did not take the written value");

  a_tx_released: assert property (run_mode && !tx_sel && !port_four_direction[P4IO_PIN_TX] |=>
    pin_oe_n[P4IO_PIN_TX])
    else $error("transmit pin driven while left as a general input");

  a_clk_input: assert property (run_mode && ck_in_sel |=> pin_oe_n[P4IO_PIN_CLK] &&
    serial_clock_in == $past(pin_sync[P4IO_PIN_CLK]))
    else $error("clock pin not an input while clock input selected");

  a_irq_follow: assert property (isel |=> irq_request_n == $past(pin_sync[P4IO_PIN_IRQ]))
    else $error("interrupt request does not follow the input pin");

  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready held for more than one cycle");

  c_data_read: cover property (rd_done && sel == P4IO_SEL_DATA);
  c_tx_drive:  cover property (run_mode && tx_sel ##1 !pin_oe_n[P4IO_PIN_TX]);
  c_clk_input: cover property (run_mode && ck_in_sel);
  c_unmapped:  cover property (pready && pslverr);
  c_hold_mode: cover property (hold_mode ##1 hold_mode);

endmodule // p4io_port

// ==== verif/p4io_far_pins.sv ====
// p4io_far_pins: circuitry on the far side of the four port pins
// assumes: outside drivers hold each pin whenever the block floats it
module p4io_far_pins
  import p4io_pkg::*;
(
  input  wire logic [3:0] ext_level,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  output logic      [2:0] pin_in,
  output logic            pin_irq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // wire level: the block wins while it drives, else the outside level
  assign pin_in     = (pin_oe_n & ext_level[2:0]) | (~pin_oe_n & pin_out);
  assign pin_irq_in = ext_level[3];
endmodule // p4io_far_pins

// ==== verif/test_port4_io_with_serial_pin_mux.sv ====
// test_port4_io_with_serial_pin_mux: self-checking bench of p4io_port
// assumes: p4io_pkg register map; far side modelled by p4io_far_pins
module test_port4_io_with_serial_pin_mux
  import p4io_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb, ext;
  p4io_mode_t  power_mode;
  logic        stx, sck, srx_in, sck_in, irq_n, pin_irq_in;
  logic [2:0]  pin_in, pin_out, pin_oe_n, lvl, dir, held;
  logic [6:0]  alt;
  logic [31:0] dv;
  logic [6:0]  tbl [8] = '{7'h06, 7'h04, 7'h08, 7'h20, 7'h10, 7'h40, 7'h30, 7'h01};
  logic [32:0] exp_q [$];
  int          mismatches, tests_run;

  p4io_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_mode(power_mode), .serial_transmit_out(stx), .serial_clock_out(sck), .serial_receive_in(srx_in),
    .serial_clock_in(sck_in), .irq_request_n(irq_n), .pin_in(pin_in), .pin_irq_in(pin_irq_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  p4io_far_pins far (.ext_level(ext), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
    .pin_irq_in(pin_irq_in));

  // ==========================================================
  // clock, reset, checking
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // answers are compared in the cycle they stand, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) check("apb_unexpected", 33'h0, 33'h1);
      else check("apb_answer", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [32:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check("pready_wait", 33'h0, 33'h1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0, {1'b0, e});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, 33'h0);
  endtask
  // expected pin view worked out from the selection tables
  task automatic pin_chk(input logic [2:0] d);
    logic tx, rx, ckin, ckout;
    logic [2:0] eoe, eout;
    tx = alt[1] & alt[2]; rx = alt[3]; ckin = alt[5]; ckout = !alt[5] & (alt[4] | alt[6]);
    eoe = {~(tx | dir[2]), rx | ~dir[1], ckin | (~ckout & ~dir[0])};
    eout = {tx ? stx : d[2], d[1], ckout ? sck : d[0]};
    lvl = (eoe & ext[2:0]) | (~eoe & eout);
    check("pin_drive", 33'({pin_oe_n, pin_out & ~eoe}), 33'({eoe, eout & ~eoe}));
    check("alt_ins", 33'({srx_in, sck_in, irq_n}),
          33'({rx ? ext[1] : 1'b1, ckin ? ext[0] : 1'b1, alt[0] ? ext[3] : 1'b1}));
  endtask

  // ==========================================================
  // stimulus
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    pstrb = 4'h0; power_mode = P4IO_ACTIVE; stx = 1'b0; sck = 1'b0; ext = 4'ha; alt = 7'h0; dir = 3'h0;
    void'($urandom(61892));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    pin_chk(3'h0);
    rd(P4IO_DIR_ADDR, 32'hff);
    rd(P4IO_ALT_ADDR, 32'h0);
    rd(P4IO_DATA_ADDR, {24'h0, 4'hf, ext});
    wr(P4IO_DIR_ADDR, 32'h7);
    rd(P4IO_DATA_ADDR, {24'h0, 4'hf, ext[3], 3'h0});
    $display("test reset_values done");
    // refused writes leave the latches alone
    apb(1'b1, P4IO_DATA_ADDR, 32'h7, 4'he, 33'h0);
    apb(1'b0, 32'h0003ff60, 32'h0, 4'h0, {1'b1, 32'h0});
    apb(1'b1, 32'h0003ff60, 32'h7, 4'hf, {1'b1, 32'h0});
    rd(P4IO_DATA_ADDR, {24'h0, 4'hf, ext[3], 3'h0});
    $display("test refused_access done");
    for (int i = 0; i < 40; i++) begin
      alt = (i < 8) ? tbl[i] : 7'($urandom);
      dir = 3'($urandom);
      dv = $urandom;
      ext <= 4'($urandom); stx <= 1'($urandom); sck <= 1'($urandom);
      wr(P4IO_ALT_ADDR, {25'h0, alt});
      wr(P4IO_DIR_ADDR, {29'($urandom), dir});
      wr(P4IO_DATA_ADDR, dv);
      repeat (4) @(posedge pclk);
      pin_chk(dv[2:0]);
      rd(P4IO_DATA_ADDR, {24'h0, 4'hf, ext[3], (dir & dv[2:0]) | (~dir & lvl)});
      rd(P4IO_DIR_ADDR, 32'hff);
    end
    $display("test pin_functions done");
    // sleep-class modes freeze the pins, standby floats them
    alt = 7'h0; dir = 3'h7; held = 3'h5;
    wr(P4IO_ALT_ADDR, 32'h0);
    wr(P4IO_DIR_ADDR, 32'h7);
    wr(P4IO_DATA_ADDR, 32'h5);
    for (int m = 0; m < 6; m++) begin
      power_mode <= p4io_mode_t'(m);
      dv = $urandom;
      wr(P4IO_DATA_ADDR, dv);
      repeat (4) @(posedge pclk);
      if (m < 2) held = dv[2:0];
      if (m == 5) check("standby_float", 33'(pin_oe_n), 33'h7);
      else check("mode_pins", 33'({pin_oe_n, pin_out}), 33'({3'h0, held}));
    end
    power_mode <= P4IO_ACTIVE;
    repeat (4) @(posedge pclk);
    check("resume", 33'({pin_oe_n, pin_out}), 33'({3'h0, dv[2:0]}));
    $display("test power_modes done");
    // reset in mid-run reloads latches and direction
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check("reset_float", 33'(pin_oe_n), 33'h7);
    wr(P4IO_DIR_ADDR, 32'h7);
    rd(P4IO_DATA_ADDR, {24'h0, 4'hf, ext[3], 3'h0});
    $display("test mid_reset done");
    final_report();
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    $display("watchdog expired");
    final_report();
  end
endmodule // test_port4_io_with_serial_pin_mux
